// [hw/rcar_pkg.sv]
// constants and types for the readout configuration and addressing block
// Notes on behaviour
// - front-end registers read back exactly what was last written; controller config keeps only its low 26 bits
// - every readback goes out as a packet with a valid parity bit
// - each front-end chip has five registers, written and read one by one
// - front-end write to chip address 31 loads all 24 chips together
// - controller accepts config writes to the broadcast controller address
// - controller answers reads only when address matches its address pins
// - config register holds enables, delay, stretch, count, size, load flags
// - hard reset pulse restores every config register to its default
// - front-end mode register bit picks the end that gets its readback
// - on reset a chip set to right goes back to left
// - soft reset command restores the controller config register
// - behaviour holds at module clocks of 14, 20 and 22 MHz
package rcar_pkg;

    localparam int DATA_W = 64;
    localparam int ID_W = 5;
    localparam int CHIP_N = 24;
    localparam int FE_REG_N = 5;
    localparam int SYNC_STAGES = 2;

    localparam logic [ID_W-1:0] FE_BCAST_ADDR = 5'h1F;
    localparam logic [ID_W-1:0] CTRL_BCAST_ADDR = 5'h1F;

    // controller register indexes
    localparam logic [2:0] CTRL_CFG_IDX = 3'h0;
    localparam logic [2:0] CTRL_SOFT_RST_IDX = 3'h1;
    localparam logic [2:0] CTRL_STATUS_IDX = 3'h2;

    // front-end register indexes
    localparam logic [2:0] FE_MODE_IDX = 3'h0;
    localparam logic [2:0] FE_DATA_MASK_IDX = 3'h1;
    localparam logic [2:0] FE_TRIG_MASK_IDX = 3'h2;
    localparam logic [2:0] FE_CAL_MASK_IDX = 3'h3;
    localparam logic [2:0] FE_DAC_IDX = 3'h4;
    localparam int FE_DIR_BIT = 0;
    localparam logic [DATA_W-1:0] FE_REG_RESET = 64'h0;

    typedef struct packed {
        logic to_fe;
        logic [ID_W-1:0] ctrl;
        logic [ID_W-1:0] fe;
        logic [2:0] reg_idx;
    } rcar_addr_s;

    typedef struct packed {
        logic over_threshold_time_enable;
        logic err_suppress;
        logic [2:0] read_delay;
        logic [4:0] trigger_stretch_length;
        logic [4:0] front_end_chip_count;
        logic [5:0] buf_size;
        logic load_flag_timeover;
        logic load_flag_delay;
        logic load_flag_stretch;
        logic load_flag_count;
        logic load_flag_size;
    } rcar_cfg_s;

    localparam int CFG_W = $bits(rcar_cfg_s);

    localparam rcar_cfg_s CFG_RESET = '{
        over_threshold_time_enable: 1'h0,
        err_suppress: 1'h0,
        read_delay: 3'h0,
        trigger_stretch_length: 5'h0,
        front_end_chip_count: 5'h18,
        buf_size: 6'h0,
        load_flag_timeover: 1'h0,
        load_flag_delay: 1'h0,
        load_flag_stretch: 1'h0,
        load_flag_count: 1'h0,
        load_flag_size: 1'h0
    };

    typedef struct packed {
        logic start;
        logic from_fe;
        logic [ID_W-1:0] addr;
        logic [2:0] reg_idx;
        logic [DATA_W-1:0] data;
        logic parity;
    } rcar_pkt_s;

endpackage

// [hw/rcar_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module rcar_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin side and synchronised side
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule
`default_nettype wire

// [hw/rcar_fe_bank.sv]
// configuration registers of the 24 front-end chips
`timescale 1ns/1ps
`default_nettype none
module rcar_fe_bank (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hard_clr,
    // write side
    input wire logic wr_en,
    input wire logic [rcar_pkg::ID_W-1:0] wr_chip,
    input wire logic [2:0] wr_idx,
    input wire logic [rcar_pkg::DATA_W-1:0] wr_data,
    // read side
    input wire logic [rcar_pkg::ID_W-1:0] rd_chip,
    input wire logic [2:0] rd_idx,
    output logic [rcar_pkg::DATA_W-1:0] rd_data,
    output logic [rcar_pkg::CHIP_N-1:0] dir_right
);
    logic [rcar_pkg::DATA_W-1:0] regs_ff
        [rcar_pkg::CHIP_N][rcar_pkg::FE_REG_N];

    genvar c;
    generate
        for (c = 0; c < rcar_pkg::CHIP_N; c++) begin : g_chip
            logic hit;
            assign hit = wr_en && (wr_chip == rcar_pkg::ID_W'(c)
                || wr_chip == rcar_pkg::FE_BCAST_ADDR);
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    for (int r = 0; r < rcar_pkg::FE_REG_N; r++) begin
                        regs_ff[c][r] <= rcar_pkg::FE_REG_RESET;
                    end
                end else if (hard_clr) begin
                    for (int r = 0; r < rcar_pkg::FE_REG_N; r++) begin
                        regs_ff[c][r] <= rcar_pkg::FE_REG_RESET;
                    end
                end else if (hit && wr_idx <= rcar_pkg::FE_DAC_IDX) begin
                    regs_ff[c][wr_idx] <= wr_data;
                end
            end
            assign dir_right[c] =
                regs_ff[c][rcar_pkg::FE_MODE_IDX][rcar_pkg::FE_DIR_BIT];
        end
    endgenerate

    always_comb begin
        rd_data = '0;
        if (rd_chip < rcar_pkg::ID_W'(rcar_pkg::CHIP_N)
            && rd_idx <= rcar_pkg::FE_DAC_IDX) begin
            rd_data = regs_ff[rd_chip][rd_idx];
        end
    end
endmodule
`default_nettype wire

// [hw/rcar_top.sv]
// end controller config, addressing, reset and front-end register access
`timescale 1ns/1ps
`default_nettype none
module rcar_top (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // register port
    input wire logic [$bits(rcar_pkg::rcar_addr_s)-1:0] REG_ADDR,
    input wire logic [rcar_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output rcar_pkg::rcar_pkt_s REG_RDATA,
    output logic REG_RD_VALID,
    // pins from the cable
    input wire logic [rcar_pkg::ID_W-1:0] CTRL_ADDR_PINS,
    input wire logic END_IS_RIGHT,
    input wire logic HARD_RESET_PULSE,
    // configuration seen by the readout logic
    output rcar_pkg::rcar_cfg_s CFG_OUT,
    output logic [rcar_pkg::CHIP_N-1:0] FE_DIR_RIGHT,
    output logic SOFT_RESET_DONE
);
    rcar_pkg::rcar_addr_s addr;
    logic [rcar_pkg::ID_W-1:0] own_addr;
    logic end_right;
    logic hard_clr;
    logic [rcar_pkg::ID_W+1:0] pins_sync;
    logic ctrl_match;
    logic ctrl_bcast;
    logic ctrl_wr_ok;
    logic ctrl_rd_ok;
    logic cfg_wr;
    logic soft_rst;
    logic fe_wr;
    logic fe_rd_ok;
    logic [rcar_pkg::DATA_W-1:0] fe_rd_data;
    logic [rcar_pkg::CHIP_N-1:0] fe_dir;
    logic fe_chip_valid;
    logic fe_dir_sel;
    rcar_pkg::rcar_cfg_s cfg_ff;
    rcar_pkg::rcar_pkt_s pkt_ff;
    rcar_pkg::rcar_pkt_s nxt_pkt;
    logic rd_valid_ff;
    logic nxt_rd_valid;
    logic [rcar_pkg::CHIP_N-1:0] fe_dir_ff;
    logic soft_done_ff;
    logic [rcar_pkg::DATA_W-1:0] status_word;

    assign addr = rcar_pkg::rcar_addr_s'(REG_ADDR);

    // pins pass two flops first
    rcar_sync #(
        .W(rcar_pkg::ID_W + 2)
    ) u_pin_sync (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .d({HARD_RESET_PULSE, END_IS_RIGHT, CTRL_ADDR_PINS}),
        .q(pins_sync)
    );

    assign own_addr = pins_sync[rcar_pkg::ID_W-1:0];
    assign end_right = pins_sync[rcar_pkg::ID_W];
    // pulse from either end ends up here
    assign hard_clr = pins_sync[rcar_pkg::ID_W+1];

    // controller address decode
    always_comb begin
        ctrl_match = (addr.ctrl == own_addr);
        ctrl_bcast = (addr.ctrl == rcar_pkg::CTRL_BCAST_ADDR);
        ctrl_wr_ok = REG_WR && (ctrl_match || ctrl_bcast);
        ctrl_rd_ok = REG_RD && ctrl_match;
    end

    // write decode
    always_comb begin
        cfg_wr = ctrl_wr_ok && !addr.to_fe
            && addr.reg_idx == rcar_pkg::CTRL_CFG_IDX;
        soft_rst = ctrl_wr_ok && !addr.to_fe
            && addr.reg_idx == rcar_pkg::CTRL_SOFT_RST_IDX;
        fe_wr = ctrl_wr_ok && addr.to_fe;
    end

    rcar_fe_bank u_fe_bank (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .hard_clr(hard_clr),
        .wr_en(fe_wr),
        .wr_chip(addr.fe),
        .wr_idx(addr.reg_idx),
        .wr_data(REG_WDATA),
        .rd_chip(addr.fe),
        .rd_idx(addr.reg_idx),
        .rd_data(fe_rd_data),
        .dir_right(fe_dir)
    );

    // front-end read qualification
    always_comb begin
        fe_chip_valid = addr.fe < rcar_pkg::ID_W'(rcar_pkg::CHIP_N)
            && addr.reg_idx <= rcar_pkg::FE_DAC_IDX;
        fe_dir_sel = 1'b0;
        if (fe_chip_valid) begin
            fe_dir_sel = fe_dir[addr.fe];
        end
        // chip answers only to the end it points at
        fe_rd_ok = ctrl_rd_ok && addr.to_fe && fe_chip_valid
            && fe_dir_sel == end_right;
    end

    // controller configuration register
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg_ff <= rcar_pkg::CFG_RESET;
        end else if (hard_clr) begin
            cfg_ff <= rcar_pkg::CFG_RESET;
        end else if (soft_rst) begin
            cfg_ff <= rcar_pkg::CFG_RESET;
        end else if (cfg_wr) begin
            cfg_ff <= rcar_pkg::rcar_cfg_s'(REG_WDATA[rcar_pkg::CFG_W-1:0]);
        end
    end

    // soft reset seen flag, cleared by the next config write
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            soft_done_ff <= 1'b0;
        end else if (soft_rst) begin
            soft_done_ff <= 1'b1;
        end else if (cfg_wr || hard_clr) begin
            soft_done_ff <= 1'b0;
        end
    end

    // status word shows own address, end and direction bits
    always_comb begin
        status_word = '0;
        status_word[rcar_pkg::ID_W-1:0] = own_addr;
        status_word[rcar_pkg::ID_W] = end_right;
        status_word[rcar_pkg::ID_W+1] = soft_done_ff;
        status_word[rcar_pkg::ID_W+2 +: rcar_pkg::CHIP_N] = fe_dir;
    end

    // readback packet assembly
    always_comb begin
        nxt_pkt = '0;
        nxt_rd_valid = 1'b0;
        if (fe_rd_ok) begin
            nxt_rd_valid = 1'b1;
            nxt_pkt.from_fe = 1'b1;
            nxt_pkt.addr = addr.fe;
            nxt_pkt.data = fe_rd_data;
        end else if (ctrl_rd_ok && !addr.to_fe) begin
            if (addr.reg_idx == rcar_pkg::CTRL_CFG_IDX) begin
                nxt_rd_valid = 1'b1;
                nxt_pkt.data = rcar_pkg::DATA_W'(cfg_ff);
            end else if (addr.reg_idx == rcar_pkg::CTRL_STATUS_IDX) begin
                nxt_rd_valid = 1'b1;
                nxt_pkt.data = status_word;
            end
            nxt_pkt.addr = own_addr;
        end
        if (nxt_rd_valid) begin
            nxt_pkt.start = 1'b1;
            nxt_pkt.reg_idx = addr.reg_idx;
            nxt_pkt.parity = ^{nxt_pkt.start, nxt_pkt.from_fe,
                nxt_pkt.addr, nxt_pkt.reg_idx, nxt_pkt.data};
        end else begin
            nxt_pkt = '0;
        end
    end

    // fixed cycle latency
    // read answer stands one cycle only
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pkt_ff <= '0;
            rd_valid_ff <= 1'b0;
        end else begin
            pkt_ff <= nxt_pkt;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    // registered copy of the chip directions
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            fe_dir_ff <= '0;
        end else begin
            fe_dir_ff <= fe_dir;
        end
    end

    assign REG_RDATA = pkt_ff;
    assign REG_RD_VALID = rd_valid_ff;
    assign CFG_OUT = cfg_ff;
    assign FE_DIR_RIGHT = fe_dir_ff;
    assign SOFT_RESET_DONE = soft_done_ff;
endmodule
`default_nettype wire

// [verification/rcar_cable_model.sv]
// cable-side model of the external readout controller
`timescale 1ns/1ps
`default_nettype none
module rcar_cable_model (
    // requests from the bench
    input wire logic pulse_left,
    input wire logic pulse_right,
    input wire logic [rcar_pkg::ID_W-1:0] addr_req,
    // cable pins
    output logic [rcar_pkg::ID_W-1:0] addr_pins,
    output logic hard_pulse
);
    assign hard_pulse = pulse_left | pulse_right;
    assign addr_pins = addr_req;
endmodule
`default_nettype wire

// [verification/rcar_sva.sv]
// assertion checker for the config, addressing and reset block
`timescale 1ns/1ps
`default_nettype none
module rcar_sva (
    // clock, reset and register port
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic [$bits(rcar_pkg::rcar_addr_s)-1:0] REG_ADDR,
    input wire logic [rcar_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire rcar_pkg::rcar_pkt_s REG_RDATA,
    input wire logic REG_RD_VALID,
    // pins and config outputs
    input wire logic [rcar_pkg::ID_W-1:0] CTRL_ADDR_PINS,
    input wire logic HARD_RESET_PULSE,
    input wire rcar_pkg::rcar_cfg_s CFG_OUT,
    input wire logic [rcar_pkg::CHIP_N-1:0] FE_DIR_RIGHT,
    input wire logic SOFT_RESET_DONE
);
    rcar_pkg::rcar_addr_s a;
    logic [3:0] hr_ff;
    logic [2:0] pc_ff;
    logic [rcar_pkg::ID_W-1:0] pin_ff;
    logic quiet, stl, own;
    assign a = REG_ADDR;
    // no hard clear in flight, address pins settled through the syncs
    assign quiet = !HARD_RESET_PULSE && hr_ff == 4'h0;
    assign stl = pc_ff == 3'h0 && CTRL_ADDR_PINS == pin_ff;
    assign own = stl && a.ctrl == CTRL_ADDR_PINS;
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            hr_ff <= 4'hF;
            pc_ff <= 3'h7;
            pin_ff <= '0;
        end else begin
            hr_ff <= {hr_ff[2:0], HARD_RESET_PULSE};
            pc_ff <= {pc_ff[1:0], CTRL_ADDR_PINS != pin_ff};
            pin_ff <= CTRL_ADDR_PINS;
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    sequence s_ctl_wr(idx);
        REG_WR && !a.to_fe && quiet && a.reg_idx == idx &&
        (own || a.ctrl == rcar_pkg::CTRL_BCAST_ADDR);
    endsequence
    sequence s_hard_held;
        HARD_RESET_PULSE [*4];
    endsequence
    chk_cfg_load: assert property (
        s_ctl_wr(rcar_pkg::CTRL_CFG_IDX) |=> !SOFT_RESET_DONE &&
        CFG_OUT == $past(REG_WDATA[rcar_pkg::CFG_W-1:0]))
        else $error("config write not loaded");
    chk_soft_reset: assert property (
        s_ctl_wr(rcar_pkg::CTRL_SOFT_RST_IDX) |=>
        CFG_OUT == rcar_pkg::CFG_RESET && SOFT_RESET_DONE)
        else $error("soft reset did not restore config");
    chk_foreign_keep: assert property (
        REG_WR && !a.to_fe && stl && quiet && a.ctrl != CTRL_ADDR_PINS &&
        a.ctrl != rcar_pkg::CTRL_BCAST_ADDR |=> $stable(CFG_OUT))
        else $error("foreign write changed config");
    chk_hard_clear: assert property (
        s_hard_held |=> CFG_OUT == rcar_pkg::CFG_RESET && FE_DIR_RIGHT == '0)
        else $error("hard reset left config set");
    chk_rd_answer: assert property (
        REG_RD && !a.to_fe && own && quiet && a.reg_idx == 3'h0 |=>
        REG_RD_VALID && REG_RDATA.addr == $past(a.ctrl) &&
        REG_RDATA.data[rcar_pkg::CFG_W-1:0] == $past(CFG_OUT))
        else $error("own config read not answered");
    chk_rd_silent: assert property (
        REG_RD && !a.to_fe && stl && a.ctrl != CTRL_ADDR_PINS |=>
        !REG_RD_VALID && REG_RDATA == '0)
        else $error("answer to foreign address");
    chk_pkt_parity: assert property (
        REG_RD_VALID |-> REG_RDATA.start && ^REG_RDATA == 1'b0 &&
        $past(REG_RD))
        else $error("bad readback packet");
    chk_fe_dir: assert property (
        REG_WR && a.to_fe && quiet && a.fe == rcar_pkg::FE_BCAST_ADDR &&
        a.reg_idx == rcar_pkg::FE_MODE_IDX &&
        (own || a.ctrl == rcar_pkg::CTRL_BCAST_ADDR) |-> ##2
        FE_DIR_RIGHT == {rcar_pkg::CHIP_N{$past(REG_WDATA[0], 2)}})
        else $error("direction bits not loaded");
endmodule
bind rcar_top rcar_sva u_rcar_sva (.CORE_CLK, .RESETN, .REG_ADDR, .REG_WDATA,
    .REG_WR, .REG_RD, .REG_RDATA, .REG_RD_VALID, .CTRL_ADDR_PINS,
    .HARD_RESET_PULSE, .CFG_OUT, .FE_DIR_RIGHT, .SOFT_RESET_DONE);
`default_nettype wire

// [verification/readout_config_addressing_reset_test.sv]
// self-checking bench for the config, addressing and reset block
`timescale 1ns/1ps
`default_nettype none
module readout_config_addressing_reset_test;
    logic CORE_CLK = 1'b0;
    logic RESETN = 1'b0;
    rcar_pkg::rcar_addr_s REG_ADDR = '0;
    logic [63:0] REG_WDATA = '0;
    logic REG_WR = 1'b0, REG_RD = 1'b0, END_IS_RIGHT = 1'b0;
    logic pulse_l = 1'b0, pulse_r = 1'b0;
    logic [4:0] addr_req = 5'h05, CTRL_ADDR_PINS;
    logic HARD_RESET_PULSE, REG_RD_VALID, SOFT_RESET_DONE;
    rcar_pkg::rcar_pkt_s REG_RDATA;
    rcar_pkg::rcar_cfg_s CFG_OUT;
    logic [23:0] FE_DIR_RIGHT;
    logic [63:0] v;
    logic [25:0] pat, c;
    int errors = 0, checks_done = 0, cyc = 0;
    rcar_top u_rcar_top (.CORE_CLK, .RESETN, .REG_ADDR, .REG_WDATA, .REG_WR,
        .REG_RD, .REG_RDATA, .REG_RD_VALID, .CTRL_ADDR_PINS, .END_IS_RIGHT,
        .HARD_RESET_PULSE, .CFG_OUT, .FE_DIR_RIGHT, .SOFT_RESET_DONE);
    rcar_cable_model u_rcar_cable_model (.pulse_left(pulse_l),
        .pulse_right(pulse_r), .addr_req, .addr_pins(CTRL_ADDR_PINS),
        .hard_pulse(HARD_RESET_PULSE));
    initial forever #12.5 CORE_CLK = ~CORE_CLK;
    function automatic rcar_pkg::rcar_addr_s ad(int f, int c, int h, int i);
        ad = '{f[0], c[4:0], h[4:0], i[2:0]};
    endfunction
    function automatic rcar_pkg::rcar_pkt_s pkt(rcar_pkg::rcar_addr_s a,
            logic [63:0] d);
        pkt = '{1'b1, a.to_fe, a.to_fe ? a.fe : a.ctrl, a.reg_idx, d, 1'b0};
        pkt.parity = ^pkt;
    endfunction
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input rcar_pkg::rcar_addr_s a, input logic [63:0] d);
        @(posedge CORE_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
        #1;
    endtask
    task automatic rd(input rcar_pkg::rcar_addr_s a, input logic ok,
            input logic [63:0] d);
        @(posedge CORE_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1;
        check({REG_RD_VALID, REG_RDATA},
            ok ? {1'b1, pkt(a, d)} : '0);
    endtask
    task automatic wait_sync();
        @(posedge CORE_CLK);
        END_IS_RIGHT <= !END_IS_RIGHT;
        repeat (4) @(posedge CORE_CLK);
    endtask
    always @(posedge CORE_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        v[31:0] = $urandom(33);
        repeat (4) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        #1;
        check({FE_DIR_RIGHT, CFG_OUT},
            {24'h0, rcar_pkg::CFG_RESET});
        pat = rcar_pkg::rcar_cfg_s'{1'b1, 1'b0, 3'h5, 5'h0A, 5'h15, 6'h2A,
            1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        v = {$urandom, $urandom};
        for (int k = 0; k < 4; k++) begin
            c = k == 3 ? pat : (k[0] ? ~v[25:0] : v[25:0]);
            wr(ad(0, k == 2 ? 31 : 5, 0, 0), {38'h0, c});
            check(CFG_OUT, c);
            rd(ad(0, 5, 0, 0), 1'b1, {38'h0, c});
        end
        wr(ad(0, 6, 0, 0), ~{38'h0, c});
        check(CFG_OUT, c);
        for (int p = 0; p < 10; p++) begin
            @(posedge CORE_CLK);
            addr_req <= p == 9 ? 5'h05 : p[4:0];
            repeat (4) @(posedge CORE_CLK);
            for (int q = 0; q < 9 && p < 9; q++)
                rd(ad(0, q, 0, 0), q == p, {38'h0, c});
        end
        for (int h = 0; h < 24; h++)
            for (int i = 0; i < 5; i++) begin
                v = {$urandom, $urandom} & ~64'(i == 0);
                wr(ad(1, 5, h, i), v);
                rd(ad(1, 5, h, i), 1'b1, v);
            end
        rd(ad(1, 5, 24, 1), 1'b0, 64'h0);
        v = {$urandom, $urandom};
        for (int i = 1; i < 5; i++) wr(ad(1, 31, 31, i), v ^ i);
        for (int h = 0; h < 24; h++)
            for (int i = 1; i < 5; i++)
                rd(ad(1, 5, h, i), 1'b1, v ^ i);
        wr(ad(1, 5, 31, 0), 64'h1);
        @(posedge CORE_CLK);
        #1;
        check(FE_DIR_RIGHT, 24'hFFFFFF);
        wait_sync();
        rd(ad(1, 5, 7, 0), 1'b1, 64'h1);
        // status: chip directions, right end, own address
        rd(ad(0, 5, 0, 2), 1'b1, 64'h7FFFFFA5);
        for (int e = 0; e < 2; e++) begin
            wr(ad(0, 5, 0, 0), {38'h0, pat});
            wr(ad(1, 5, 31, 0), 64'h1);
            @(posedge CORE_CLK);
            {pulse_r, pulse_l} <= e ? 2'b10 : 2'b01;
            repeat (4) @(posedge CORE_CLK);
            {pulse_r, pulse_l} <= 2'b00;
            repeat (4) @(posedge CORE_CLK);
            #1;
            check({FE_DIR_RIGHT, CFG_OUT},
                {24'h0, rcar_pkg::CFG_RESET});
        end
        wait_sync();
        rd(ad(1, 5, 3, 0), 1'b1, 64'h0);
        rd(ad(0, 5, 0, 0), 1'b1, {38'h0, rcar_pkg::CFG_RESET});
        wr(ad(0, 5, 0, 0), {38'h0, pat});
        wr(ad(0, 5, 0, 1), v);
        check({SOFT_RESET_DONE, CFG_OUT},
            {1'b1, rcar_pkg::CFG_RESET});
        // status: soft reset seen, left end, own address
        rd(ad(0, 5, 0, 2), 1'b1, 64'h45);
        wr(ad(0, 31, 0, 0), {38'h0, pat});
        check(SOFT_RESET_DONE, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
